/* File: rtl/tls_defs.svh */
`ifndef TLS_DEFS_SVH
`define TLS_DEFS_SVH

// code shown on the diagnostic display for a travel-limit trip
`define TLS_DIAG_LIMIT 8'h2c
// display value while no travel-limit fault is pending
`define TLS_DIAG_NONE  8'h00
// bit positions of the two limit inputs
`define TLS_BIT_POS    0
`define TLS_BIT_NEG    1
// reset value of every synchroniser stage
`define TLS_SYNC_RST   2'h0
// edge memory starts high: no false edge out of reset, whatever the
// polarity; a switch already held at reset gives no edge only when inverted, else one edge
`define TLS_PREV_RST   2'h3
// hardware bound is the safe side while in reset
`define TLS_HWB_RST    1'b1

`endif

/* File: rtl/tls_pkg.sv */
`default_nettype none

package tls_pkg;

    typedef enum logic [0:0] {
        TLS_RUN  = 1'b0,
        TLS_TRIP = 1'b1
    } tls_state_t;

    typedef logic [1:0] tls_pair_t;

endpackage : tls_pkg

`default_nettype wire

/* File: rtl/tls_if.sv */
`default_nettype none

interface tls_if;
    import tls_pkg::*;

    tls_pair_t lvl;
    tls_pair_t rise;

    modport src (output lvl, output rise);
    modport snk (input lvl, input rise);
endinterface : tls_if

`default_nettype wire

/* File: rtl/tls_edge.sv */
`include "tls_defs.svh"
`default_nettype none

module tls_edge
    import tls_pkg::*;
(
    // clock and reset
    input  wire logic      ref_clk_i,
    input  wire logic      rst_b_i,
    // raw limit pins and polarity
    input  wire tls_pair_t lim_raw_i,
    input  wire logic      invert_i,
    // levels and rising edges to the supervisor
    tls_if.src             lim
);

    ////////////////////////////////////////////////////////////////////////
    tls_pair_t meta;
    tls_pair_t sync;
    tls_pair_t prev;
    tls_pair_t next_meta;
    tls_pair_t next_sync;
    tls_pair_t next_prev;
    tls_pair_t lvl;

    // only the second stage is ever looked at
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_bit
            always_comb
            begin
                next_meta[gi] = lim_raw_i[gi];
                next_sync[gi] = meta[gi];
                lvl[gi]       = sync[gi] ^ invert_i;
                next_prev[gi] = lvl[gi];
            end
            assign lim.rise[gi] = lvl[gi] & ~prev[gi];
        end
    endgenerate

    assign lim.lvl = lvl;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta <= `TLS_SYNC_RST;
            sync <= `TLS_SYNC_RST;
            prev <= `TLS_PREV_RST;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

endmodule : tls_edge

`default_nettype wire

/* File: rtl/tls_top.sv */
`include "tls_defs.svh"
`default_nettype none

module tls_top
    import tls_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    // limit switch pins and polarity setting
    input  wire logic       lim_pos_i,
    input  wire logic       lim_neg_i,
    input  wire logic       lim_invert_i,
    // reference and soft limits
    input  wire logic       ref_valid_i,
    input  wire logic       sw_lim_en_i,
    // control requests
    input  wire logic       fault_reset_i,
    input  wire logic       power_req_i,
    input  wire logic       cmd_valid_i,
    input  wire logic       cmd_dir_pos_i,
    // reports to the control
    output logic            fault_o,
    output logic            fault_evt_o,
    output logic            fired_pos_o,
    output logic            fired_neg_o,
    output logic [7:0]      diag_display_o,
    // drive package
    output logic            power_en_o,
    // command answers and recovery direction
    output logic            cmd_accept_o,
    output logic            cmd_reject_o,
    output logic            allow_pos_o,
    output logic            allow_neg_o,
    // limit supervision status
    output logic            cable_break_o,
    output logic            sw_lim_active_o,
    output logic            hw_bound_o
);

    ////////////////////////////////////////////////////////////////////////
    tls_if lim ();

    tls_edge u_edge (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .lim_raw_i ({lim_neg_i, lim_pos_i}),
        .invert_i  (lim_invert_i),
        .lim       (lim.src)
    );

    ////////////////////////////////////////////////////////////////////////
    tls_state_t state;
    tls_state_t next_state;
    logic       next_fired_pos;
    logic       next_fired_neg;
    logic [7:0] next_diag;
    logic       next_evt;
    logic       next_power;
    logic       next_accept;
    logic       next_reject;
    logic       next_allow_pos;
    logic       next_allow_neg;
    logic       next_cable;
    logic       next_sw_lim;
    logic       next_hw_bound;
    logic       on_pos;
    logic       on_neg;
    logic       bad_cmd;
    logic       trip_pos;
    logic       trip_neg;
    logic       trip;

    assign on_pos = lim.lvl[`TLS_BIT_POS];
    assign on_neg = lim.lvl[`TLS_BIT_NEG];

    always_comb
    begin
        // a command heading further onto an active limit
        bad_cmd  = cmd_valid_i && ((cmd_dir_pos_i && on_pos) ||
                                   (!cmd_dir_pos_i && on_neg));
        trip_pos = lim.rise[`TLS_BIT_POS] ||
                   (bad_cmd && cmd_dir_pos_i);
        trip_neg = lim.rise[`TLS_BIT_NEG] ||
                   (bad_cmd && !cmd_dir_pos_i);
        trip     = trip_pos || trip_neg;

        next_state     = state;
        next_fired_pos = fired_pos_o;
        next_fired_neg = fired_neg_o;
        // reset taken regardless of live switch level; new event wins
        if (fault_reset_i)
        begin
            next_state     = TLS_RUN;
            next_fired_pos = 1'b0;
            next_fired_neg = 1'b0;
        end
        if (trip)
        begin
            next_state = TLS_TRIP;
        end
        if (trip_pos)
        begin
            next_fired_pos = 1'b1;
        end
        if (trip_neg)
        begin
            next_fired_neg = 1'b1;
        end

        case (next_state)
            TLS_RUN:  next_diag = `TLS_DIAG_NONE;
            TLS_TRIP: next_diag = `TLS_DIAG_LIMIT;
            default:  next_diag = `TLS_DIAG_NONE;
        endcase

        next_evt    = trip;
        // only this package loses power; stop chain left alone
        next_power  = power_req_i && (next_state == TLS_RUN);
        next_accept = cmd_valid_i && !bad_cmd;
        next_reject = bad_cmd;
        // direction away from whichever limit is held
        next_allow_pos = !on_pos && !(state == TLS_TRIP && fired_pos_o);
        next_allow_neg = !on_neg && !(state == TLS_TRIP && fired_neg_o);
        // broken wire on closed-type switches reads as both active
        next_cable  = lim_invert_i && on_pos && on_neg;
        next_sw_lim = sw_lim_en_i && ref_valid_i;
        next_hw_bound = !next_sw_lim;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state           <= TLS_RUN;
            fired_pos_o     <= 1'b0;
            fired_neg_o     <= 1'b0;
            diag_display_o  <= `TLS_DIAG_NONE;
            fault_evt_o     <= 1'b0;
            power_en_o      <= 1'b0;
            cmd_accept_o    <= 1'b0;
            cmd_reject_o    <= 1'b0;
            allow_pos_o     <= 1'b0;
            allow_neg_o     <= 1'b0;
            cable_break_o   <= 1'b0;
            sw_lim_active_o <= 1'b0;
            hw_bound_o      <= `TLS_HWB_RST;
        end
        else
        begin
            state           <= next_state;
            fired_pos_o     <= next_fired_pos;
            fired_neg_o     <= next_fired_neg;
            diag_display_o  <= next_diag;
            fault_evt_o     <= next_evt;
            power_en_o      <= next_power;
            cmd_accept_o    <= next_accept;
            cmd_reject_o    <= next_reject;
            allow_pos_o     <= next_allow_pos;
            allow_neg_o     <= next_allow_neg;
            cable_break_o   <= next_cable;
            sw_lim_active_o <= next_sw_lim;
            hw_bound_o      <= next_hw_bound;
        end
    end

    assign fault_o = (state == TLS_TRIP);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_EDGE_TRIPS: assert property (
        |lim.rise |=> fault_o && fault_evt_o)
        else $error("limit edge did not raise fault");

    AST_SIDE_POS: assert property (
        lim.rise[`TLS_BIT_POS] |=> fired_pos_o)
        else $error("positive limit not recorded");

    AST_POWER_CUT: assert property (
        |lim.rise |=> !power_en_o)
        else $error("power still on after limit edge");

    AST_DIAG_CODE: assert property (
        $rose(fault_o) |-> diag_display_o == `TLS_DIAG_LIMIT)
        else $error("display does not show code 44");

    AST_RESET_ON_LIMIT: assert property (
        fault_reset_i && !trip && (on_pos || on_neg) |=> !fault_o)
        else $error("reset refused while limit active");

    AST_POWER_AFTER_CLEAR: assert property (
        power_en_o |-> !fault_o && $past(power_req_i))
        else $error("power enabled during fault");

    AST_CMD_BACK: assert property (
        cmd_valid_i && !cmd_dir_pos_i && on_pos && !on_neg
        |=> cmd_accept_o && !cmd_reject_o)
        else $error("recovery command refused");

    AST_CMD_OUT: assert property (
        cmd_valid_i && cmd_dir_pos_i && on_pos
        |=> cmd_reject_o && fault_o && !power_en_o
            && diag_display_o == `TLS_DIAG_LIMIT)
        else $error("outward command not refused");

    AST_RECOVER_DIR: assert property (
        on_pos |=> !allow_pos_o)
        else $error("positive travel allowed on positive limit");

    AST_CABLE: assert property (
        cable_break_o |-> $past(lim_invert_i))
        else $error("cable break without inversion bit");

    AST_SW_LIM_REF: assert property (
        !ref_valid_i |=> !sw_lim_active_o ##0 hw_bound_o)
        else $error("soft limits active without reference");

    AST_FAULT_HOLD: assert property (
        fault_o && !fault_reset_i |=> fault_o [*1] ##0 !power_en_o)
        else $error("fault dropped without reset");

    COV_TRIP: cover property (|lim.rise ##1 fault_o);
    COV_RESET_ON_LIMIT: cover property (
        fault_o && fault_reset_i && on_pos ##1 !fault_o);
    COV_REJECT: cover property (cmd_reject_o ##1 fault_o);
    COV_RECOVER: cover property (fault_o ##1 !fault_o ##1 cmd_accept_o);

endmodule : tls_top

`default_nettype wire

/* File: testbench/tls_nc_model.sv */
`default_nettype none

module tls_nc_model
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    // drive status and clear request
    input  wire logic       fault_i,
    input  wire logic       clr_req_i,
    input  wire logic [3:0] delay_i,
    // fault reset to the drive
    output logic            fault_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] cnt;

    // delay_i lets the control answer promptly or slowly
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt           <= 4'h0;
            fault_reset_o <= 1'b0;
        end
        else
        begin
            fault_reset_o <= 1'b0;
            if (!(clr_req_i && fault_i))
                cnt <= 4'h0;
            else if (cnt < delay_i)
                cnt <= cnt + 4'h1;
            else if (!fault_reset_o)
                fault_reset_o <= 1'b1;
        end
    end
endmodule : tls_nc_model

`default_nettype wire

/* File: testbench/travel_limit_supervisor_tb.sv */
`default_nettype none

module travel_limit_supervisor_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rst_b, lp, ln, inv, refv, swen, preq, cv, cd, clr, frst;
    logic fault, evt, fp, fn, pwr, acc, rej, ap, an, cbrk, swa, hwb;
    logic [7:0]  diag;
    logic [3:0]  dly;
    logic [5:0]  q[$];
    logic [5:0]  e, s;
    logic [31:0] r;
    logic        d;
    int          error_cnt, n_checks, i;

    tls_top dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .lim_pos_i(lp),
        .lim_neg_i(ln), .lim_invert_i(inv), .ref_valid_i(refv),
        .sw_lim_en_i(swen), .fault_reset_i(frst), .power_req_i(preq),
        .cmd_valid_i(cv), .cmd_dir_pos_i(cd), .fault_o(fault),
        .fault_evt_o(evt), .fired_pos_o(fp), .fired_neg_o(fn),
        .diag_display_o(diag), .power_en_o(pwr), .cmd_accept_o(acc),
        .cmd_reject_o(rej), .allow_pos_o(ap), .allow_neg_o(an),
        .cable_break_o(cbrk), .sw_lim_active_o(swa), .hw_bound_o(hwb));

    tls_nc_model nc_u (.ref_clk_i(clk), .rst_b_i(rst_b), .fault_i(fault),
        .clr_req_i(clr), .delay_i(dly), .fault_reset_o(frst));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] x);
        n_checks++;
        if (seen !== x)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, x, seen);
        end
    endtask : check

    task finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    function logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    // leaves cmd_valid high so commands can run back to back
    task cmd(input logic dir, input logic [5:0] x);
        @(posedge clk);
        cv <= 1'b1;
        cd <= dir;
        q.push_back(x);
    endtask : cmd

    task drain;
        for (i = 0; i < 30 && q.size() > 0; i++)
            @(posedge clk);
        check("queue", 8'(q.size()), 8'h00);
        if (q.size() > 0)
            finish_test();
    endtask : drain

    task clear(input logic [3:0] dl);
        @(posedge clk);
        dly <= dl;
        clr <= 1'b1;
        for (i = 0; i < 40 && fault !== 1'b0; i++)
            @(negedge clk);
        check("fired", 8'({fp, fn, fault}), 8'h00);
        check("power", 8'(pwr), 8'h01);
        if (fault !== 1'b0)
            finish_test();
        @(posedge clk);
        clr <= 1'b0;
    endtask : clear

    ////////////////////////////////////////////////////////////////////////
    // results are matched in order against the driver's notes
    always @(negedge clk)
    begin
        if (rst_b === 1'b1 && (evt | acc | rej) === 1'b1)
        begin
            if (q.size() > 0)
                e = q.pop_front();
            else
                e = 6'h00;
            s = {evt, acc, rej, fp, fn, pwr};
            check("result", 8'(s), 8'(e));
            if (evt === 1'b1)
                check("diag", diag, 8'h2c);
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        {rst_b, lp, ln, inv, refv, preq, cv, cd, clr} = 9'h000;
        swen = 1'b1;
        dly = 4'h0;
        error_cnt = 0;
        n_checks = 0;
        r = 32'h0000000a;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        check("bound", 8'({hwb, swa}), 8'h02);
        refv <= 1'b1;
        repeat (3) @(posedge clk);
        check("bound", 8'({hwb, swa}), 8'h01);
        // reference kept but soft limits switched off
        swen <= 1'b0;
        repeat (3) @(posedge clk);
        check("bound", 8'({hwb, swa}), 8'h02);
        swen <= 1'b1;
        refv <= 1'b0;
        preq <= 1'b1;
        repeat (3) @(posedge clk);
        check("bound", 8'({hwb, pwr}), 8'h03);
        for (int k = 0; k < 8; k++)
        begin
            r = xs(r);
            cmd(r[0], 6'h11);
        end
        @(posedge clk);
        cv <= 1'b0;
        drain();
        for (int k = 0; k < 2; k++)
        begin
            d = k[0];
            @(posedge clk);
            lp <= d;
            ln <= ~d;
            q.push_back({3'b100, d, ~d, 1'b0});
            drain();
            check("allow", 8'({ap, an}), 8'({~d, d}));
            repeat (2) @(posedge clk);
            check("power", 8'(pwr), 8'h00);
            // limit still active while the control resets
            clear(d ? 4'h5 : 4'h0);
            cmd(~d, 6'h11);
            cmd(d, {3'b101, d, ~d, 1'b0});
            @(posedge clk);
            cv <= 1'b0;
            drain();
            lp <= 1'b0;
            ln <= 1'b0;
            repeat (5) @(posedge clk);
            check("held", 8'({fault, fp, fn}), 8'({1'b1, d, ~d}));
            check("diag", diag, 8'h2c);
            check("allow", 8'({ap, an}), 8'({~d, d}));
            clear(4'h2);
        end
        // both pins high without inversion is no cable break
        @(posedge clk);
        lp <= 1'b1;
        ln <= 1'b1;
        q.push_back(6'h26);
        drain();
        check("cable", 8'(cbrk), 8'h00);
        inv <= 1'b1;
        repeat (4) @(posedge clk);
        clear(4'h1);
        lp <= 1'b0;
        ln <= 1'b0;
        q.push_back(6'h26);
        drain();
        check("cable", 8'(cbrk), 8'h01);
        finish_test();
    end
endmodule : travel_limit_supervisor_tb

`default_nettype wire
